// ===== include/aio_consts.svh
// Register offsets, field positions and reset values of the analog I/O scan block
`ifndef AIO_CONSTS_SVH
`define AIO_CONSTS_SVH

`define AIO_IN1_VALUE_IDX      8'he8
`define AIO_IN2_VALUE_IDX      8'he9
`define AIO_IN3_VALUE_IDX      8'hea
`define AIO_IN4_VALUE_IDX      8'heb
`define AIO_OUT1_SETTING_IDX   8'hec
`define AIO_OUT2_SETTING_IDX   8'hed
`define AIO_SYS_FLAG_IDX       8'hfe
`define AIO_ERR_CODE_IDX       8'h04
`define AIO_RANGE_CFG_IDX      8'hf0

`define AIO_CFG_RANGE_LSB      0
`define AIO_CFG_DISABLE_LSB    8
`define AIO_CFG_SPARE_LSB      12
`define AIO_ERR_CODE_LSB       8
`define AIO_SYS_FAULT_BIT      15

`define AIO_ERR_NONE           8'h00
`define AIO_ERR_HARDWARE       8'h01
`define AIO_ERR_SETUP          8'h03
`define AIO_ERR_CONVERSION     8'h04

`define AIO_RANGE_CFG_RESET    16'h0000
`define AIO_SYS_FLAG_RESET     16'h0000
`define AIO_OUT_SETTING_RESET  16'h0000
`define AIO_BIPOLAR_OFFSET     12'h800

`endif

// ===== include/aio_pkg.sv
// Types shared by the analog I/O scan block
package aio_pkg;
    typedef enum logic [1:0] {
        AIO_RANGE_BIPOLAR_10V,
        AIO_RANGE_UNIPOLAR_10V,
        AIO_RANGE_UNIPOLAR_5V_CURRENT,
        AIO_RANGE_UNUSED
    } aio_range_t;

    typedef logic [15:0] aio_word_t;
    typedef logic [11:0] aio_conv_t;
    typedef logic [7:0]  aio_index_t;
endpackage

// ===== hdl/aio_scan_interface.sv
// Analog I/O scan-cycle interface: four converted inputs, two outputs, setup and status words
`timescale 1ns/1ns
`default_nettype none
`include "aio_consts.svh"

module aio_scan_interface (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              scan_tick,
    input  wire aio_pkg::aio_index_t reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire aio_pkg::aio_word_t  reg_wdata,
    output aio_pkg::aio_word_t     reg_rdata,
    input  wire aio_pkg::aio_conv_t  adc_in1_raw,
    input  wire aio_pkg::aio_conv_t  adc_in2_raw,
    input  wire aio_pkg::aio_conv_t  adc_in3_raw,
    input  wire aio_pkg::aio_conv_t  adc_in4_raw,
    input  wire logic              hw_fault_in,
    input  wire logic              conv_fault_in,
    output aio_pkg::aio_conv_t     dac_out1_volt_code,
    output aio_pkg::aio_conv_t     dac_out1_curr_code,
    output aio_pkg::aio_conv_t     dac_out2_volt_code,
    output aio_pkg::aio_conv_t     dac_out2_curr_code,
    output logic                   io_ready
);
    import aio_pkg::*;

    // Raw converter result to data word by range code
    function automatic aio_word_t conv_word(input aio_conv_t raw, input logic [1:0] code);
        aio_conv_t centred;
        centred = raw - `AIO_BIPOLAR_OFFSET;
        if (aio_range_t'(code) == AIO_RANGE_BIPOLAR_10V) begin
            conv_word = {{4{centred[11]}}, centred};
        end else begin
            conv_word = {4'h0, raw};
        end
    endfunction

    // Setting word to voltage converter code, offset binary
    function automatic aio_conv_t volt_code(input aio_word_t setting);
        volt_code = setting[11:0] + `AIO_BIPOLAR_OFFSET;
    endfunction

    // Setting word to current converter code, scaled to full span
    function automatic aio_conv_t curr_code(input aio_word_t setting);
        curr_code = {setting[10:0], 1'b0};
    endfunction

    // Register write strobe aimed at one word index
    function automatic logic wr_hit(input logic wr, input aio_index_t addr,
                                    input aio_index_t idx);
        wr_hit = wr && (addr == idx);
    endfunction

    // Two-bit range code of one input from a configuration word
    function automatic logic [1:0] range_of(input aio_word_t cfg, input int unsigned idx);
        range_of = cfg[`AIO_CFG_RANGE_LSB + 2*idx +: 2];
    endfunction

    // Conversion enable of one input, active when its disable bit is clear
    function automatic logic conv_on(input aio_word_t cfg, input int unsigned idx);
        conv_on = !cfg[`AIO_CFG_DISABLE_LSB + idx];
    endfunction

    // Any nonzero error code is a reported board fault
    function automatic logic code_is_fault(input logic [7:0] code);
        code_is_fault = (code != `AIO_ERR_NONE);
    endfunction

    aio_conv_t  raw_meta [4];
    aio_conv_t  raw_sync [4];
    aio_conv_t  raw_now  [4];
    logic [1:0] hw_meta_reg;
    logic [1:0] conv_meta_reg;
    logic       hw_fault_s;
    logic       conv_fault_s;

    aio_word_t  in_value_reg [4];
    aio_word_t  out1_setting_reg;
    aio_word_t  out2_setting_reg;
    aio_word_t  range_cfg_reg;
    aio_word_t  active_cfg_reg;
    logic       cfg_taken_reg;
    logic [14:0] sys_flag_reg;
    logic [7:0] err_code_reg;
    logic [7:0] err_code_next;
    logic       setup_bad;
    aio_word_t  rdata_next;
    logic [3:0] conv_en;
    logic [1:0] range_code [4];
    logic       board_fault_reg;
    logic       wr_cfg;
    logic       wr_out1;
    logic       wr_out2;
    logic       wr_flag;

    assign raw_now[0] = adc_in1_raw;
    assign raw_now[1] = adc_in2_raw;
    assign raw_now[2] = adc_in3_raw;
    assign raw_now[3] = adc_in4_raw;
    assign hw_fault_s   = hw_meta_reg[1];
    assign conv_fault_s = conv_meta_reg[1];
    assign wr_cfg  = wr_hit(reg_wr, reg_addr, `AIO_RANGE_CFG_IDX);
    assign wr_out1 = wr_hit(reg_wr, reg_addr, `AIO_OUT1_SETTING_IDX);
    assign wr_out2 = wr_hit(reg_wr, reg_addr, `AIO_OUT2_SETTING_IDX);
    assign wr_flag = wr_hit(reg_wr, reg_addr, `AIO_SYS_FLAG_IDX);

    // Per-input enable and range code of the taken configuration
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            conv_en[i]    = conv_on(active_cfg_reg, i);
            range_code[i] = range_of(active_cfg_reg, i);
        end
    end

    // Two-stage synchronisers for the converter result pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                raw_meta[i] <= 12'h000;
                raw_sync[i] <= 12'h000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                raw_meta[i] <= raw_now[i];
                raw_sync[i] <= raw_meta[i];
            end
        end
    end

    // Two-stage synchronisers for the fault pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hw_meta_reg   <= 2'b00;
            conv_meta_reg <= 2'b00;
        end else begin
            hw_meta_reg   <= {hw_meta_reg[0], hw_fault_in};
            conv_meta_reg <= {conv_meta_reg[0], conv_fault_in};
        end
    end

    // Software-written configuration word, taken into use only at the first scan tick after reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            range_cfg_reg <= `AIO_RANGE_CFG_RESET;
        end else if (wr_cfg) begin
            range_cfg_reg <= reg_wdata;
        end
    end

    // Configuration taken once, at the first scan tick after reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_cfg_reg <= `AIO_RANGE_CFG_RESET;
            cfg_taken_reg  <= 1'b0;
        end else if (scan_tick && !cfg_taken_reg) begin
            active_cfg_reg <= range_cfg_reg;
            cfg_taken_reg  <= 1'b1;
        end
    end

    // Enabled input data words refreshed on each scan tick after the configuration is taken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                in_value_reg[i] <= 16'h0000;
            end
        end else if (scan_tick && cfg_taken_reg) begin
            for (int i = 0; i < 4; i++) begin
                if (conv_en[i]) begin
                    in_value_reg[i] <= conv_word(raw_sync[i], range_code[i]);
                end
            end
        end
    end

    // Output 1 setting word written by software
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out1_setting_reg <= `AIO_OUT_SETTING_RESET;
        end else if (wr_out1) begin
            out1_setting_reg <= reg_wdata;
        end
    end

    // Output 2 setting word written by software
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out2_setting_reg <= `AIO_OUT_SETTING_RESET;
        end else if (wr_out2) begin
            out2_setting_reg <= reg_wdata;
        end
    end

    // Output 1 codes picked up once per scan tick; both types always driven
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dac_out1_volt_code <= `AIO_BIPOLAR_OFFSET;
            dac_out1_curr_code <= 12'h000;
        end else if (scan_tick) begin
            dac_out1_volt_code <= volt_code(out1_setting_reg);
            dac_out1_curr_code <= curr_code(out1_setting_reg);
        end
    end

    // Output 2 codes picked up once per scan tick; both types always driven
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dac_out2_volt_code <= `AIO_BIPOLAR_OFFSET;
            dac_out2_curr_code <= 12'h000;
        end else if (scan_tick) begin
            dac_out2_volt_code <= volt_code(out2_setting_reg);
            dac_out2_curr_code <= curr_code(out2_setting_reg);
        end
    end

    // Setup check on the taken configuration
    always_comb begin
        setup_bad = (active_cfg_reg[15:`AIO_CFG_SPARE_LSB] != 4'h0);
        for (int i = 0; i < 4; i++) begin
            if (conv_en[i] &&
                range_code[i] == 2'(AIO_RANGE_UNUSED)) begin
                setup_bad = 1'b1;
            end
        end
    end

    // Error code priority: hardware, setup, conversion
    always_comb begin
        if (hw_fault_s) begin
            err_code_next = `AIO_ERR_HARDWARE;
        end else if (cfg_taken_reg && setup_bad) begin
            err_code_next = `AIO_ERR_SETUP;
        end else if (conv_fault_s) begin
            err_code_next = `AIO_ERR_CONVERSION;
        end else begin
            err_code_next = `AIO_ERR_NONE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_code_reg <= `AIO_ERR_NONE;
        end else begin
            err_code_reg <= err_code_next;
        end
    end

    // Board fault flag, registered alongside the error code
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            board_fault_reg <= 1'b0;
        end else begin
            board_fault_reg <= code_is_fault(err_code_next);
        end
    end

    // Low bits of the system flag word are plain storage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sys_flag_reg <= 15'(`AIO_SYS_FLAG_RESET);
        end else if (wr_flag) begin
            sys_flag_reg <= reg_wdata[14:0];
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        unique case (reg_addr)
            `AIO_IN1_VALUE_IDX:    rdata_next = in_value_reg[0];
            `AIO_IN2_VALUE_IDX:    rdata_next = in_value_reg[1];
            `AIO_IN3_VALUE_IDX:    rdata_next = in_value_reg[2];
            `AIO_IN4_VALUE_IDX:    rdata_next = in_value_reg[3];
            `AIO_OUT1_SETTING_IDX: rdata_next = out1_setting_reg;
            `AIO_OUT2_SETTING_IDX: rdata_next = out2_setting_reg;
            `AIO_SYS_FLAG_IDX:     rdata_next = {board_fault_reg,
                                                 sys_flag_reg};
            `AIO_ERR_CODE_IDX:     rdata_next = {err_code_reg, 8'h00};
            `AIO_RANGE_CFG_IDX:    rdata_next = range_cfg_reg;
            default:               rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            io_ready <= 1'b0;
        end else begin
            io_ready <= cfg_taken_reg && !code_is_fault(err_code_next);
        end
    end

endmodule // aio_scan_interface

`default_nettype wire

// ===== sim/aio_scan_chk.sv
// Port-level assertions for the analog I/O scan block
`timescale 1ns/1ns
`default_nettype none
module aio_scan_chk (
    input wire logic                clk,
    input wire logic                resetn,
    input wire logic                scan_tick,
    input wire aio_pkg::aio_index_t reg_addr,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire aio_pkg::aio_word_t  reg_wdata,
    input wire aio_pkg::aio_word_t  reg_rdata,
    input wire logic                hw_fault_in,
    input wire aio_pkg::aio_conv_t  dac_out1_volt_code,
    input wire aio_pkg::aio_conv_t  dac_out1_curr_code,
    input wire logic                io_ready
);
    import aio_pkg::*;
    aio_word_t s1_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Shadow of output 1 setting
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) s1_reg <= 16'h0000;
        else if (reg_wr && reg_addr == 8'hec) s1_reg <= reg_wdata;
    end
    property p_out1_volt; scan_tick && !reg_wr |=> dac_out1_volt_code == 12'($past(s1_reg)) + 12'h800; endproperty
    a_out1_volt: assert property (p_out1_volt) else $error("out1 volt code wrong");
    property p_out1_curr; scan_tick && !reg_wr |=> dac_out1_curr_code == {$past(s1_reg[10:0]), 1'b0}; endproperty
    a_out1_curr: assert property (p_out1_curr) else $error("out1 curr code wrong");
    property p_out1_hold; !scan_tick |=> $stable(dac_out1_volt_code); endproperty
    a_out1_hold: assert property (p_out1_hold) else $error("out1 changed off tick");
    property p_set_rdbk; reg_rd && reg_addr == 8'hec && !reg_wr |=> reg_rdata == $past(s1_reg); endproperty
    a_set_rdbk: assert property (p_set_rdbk) else $error("setting readback wrong");
    property p_hw_code; hw_fault_in [*4] ##1 hw_fault_in && reg_rd && reg_addr == 8'h04 |=> reg_rdata[15:8] == 8'h01; endproperty
    a_hw_code: assert property (p_hw_code) else $error("hw fault code wrong");
    property p_fault_flag; hw_fault_in [*4] ##1 hw_fault_in && reg_rd && reg_addr == 8'hfe |=> reg_rdata[15]; endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault flag low");
    property p_not_ready; hw_fault_in [*6] |-> !io_ready; endproperty
    a_not_ready: assert property (p_not_ready) else $error("ready during fault");
    property p_ok_flag; io_ready [*5] ##0 reg_rd && reg_addr == 8'hfe |=> !reg_rdata[15]; endproperty
    a_ok_flag: assert property (p_ok_flag) else $error("flag high while ready");
endmodule // aio_scan_chk
bind aio_scan_interface aio_scan_chk chk (.clk(clk), .resetn(resetn), .scan_tick(scan_tick),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .hw_fault_in(hw_fault_in), .dac_out1_volt_code(dac_out1_volt_code),
    .dac_out1_curr_code(dac_out1_curr_code), .io_ready(io_ready));
`default_nettype wire

// ===== sim/aio_sensor_model.sv
// Behavioural converter channels and fault pins
`timescale 1ns/1ns
`default_nettype none
module aio_sensor_model (
    input  wire logic         clk,
    input  wire logic [47:0]  level,
    input  wire logic [1:0]   flt,
    output aio_pkg::aio_conv_t raw1,
    output aio_pkg::aio_conv_t raw2,
    output aio_pkg::aio_conv_t raw3,
    output aio_pkg::aio_conv_t raw4,
    output logic              hw_fault,
    output logic              conv_fault
);
    import aio_pkg::*;
    // Each channel settles one cycle after its level changes
    always_ff @(posedge clk) begin
        {raw4, raw3, raw2, raw1} <= level;
        {conv_fault, hw_fault} <= flt;
    end
endmodule // aio_sensor_model
`default_nettype wire

// ===== sim/aio_scan_interface_tb_top.sv
// Self-checking bench for the analog I/O scan block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module aio_scan_interface_tb_top;
    import aio_pkg::*;
    logic        clk = 0;
    logic        resetn = 0;
    logic        scan_tick = 0;
    logic        reg_wr = 0;
    logic        reg_rd = 0;
    aio_index_t  reg_addr = 8'h00;
    aio_word_t   reg_wdata = 16'h0000;
    aio_word_t   reg_rdata;
    aio_conv_t   r1, r2, r3, r4, v1, v2, c1, c2;
    logic        hw, cf, io_ready;
    logic [47:0] level = 48'h0;
    logic [1:0]  flt = 2'b00;
    int          fail_count = 0;
    int          comparisons = 0;
    always #2 clk = ~clk;
    aio_sensor_model model (.clk(clk), .level(level), .flt(flt), .raw1(r1), .raw2(r2),
        .raw3(r3), .raw4(r4), .hw_fault(hw), .conv_fault(cf));
    aio_scan_interface uut (.clk(clk), .resetn(resetn), .scan_tick(scan_tick),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .adc_in1_raw(r1), .adc_in2_raw(r2), .adc_in3_raw(r3),
        .adc_in4_raw(r4), .hw_fault_in(hw), .conv_fault_in(cf), .dac_out1_volt_code(v1),
        .dac_out1_curr_code(c1), .dac_out2_volt_code(v2), .dac_out2_curr_code(c2),
        .io_ready(io_ready));
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input aio_index_t a, input aio_word_t d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        step();
        reg_wr = 0;
        step();
    endtask
    task automatic rd(input aio_index_t a, input aio_word_t e);
        reg_addr = a;
        reg_rd = 1;
        step();
        reg_rd = 0;
        `CHK("reg_rdata", e, reg_rdata)
        step();
    endtask
    task automatic tick();
        scan_tick = 1;
        step();
        scan_tick = 0;
        repeat (2) step();
    endtask
    task automatic do_reset();
        resetn = 0;
        repeat (3) step();
        resetn = 1;
        step();
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5000) step();
        fail_count++;
        print_verdict();
    end
    initial begin
        do_reset();
        `CHK("io_ready", 1'b0, io_ready)
        rd(8'h04, 16'h0000);
        rd(8'h10, 16'h0000);
        wr(8'hf0, 16'h0824);
        tick();
        wr(8'hf0, 16'h0000);
        level = {12'h555, 12'h123, 12'hfff, 12'h000};
        repeat (4) step();
        tick();
        rd(8'he8, 16'hf800);
        rd(8'he9, 16'h0fff);
        rd(8'hea, 16'h0123);
        rd(8'heb, 16'h0000);
        level = {12'h555, 12'h000, 12'h000, 12'hfff};
        repeat (4) step();
        tick();
        wr(8'he8, 16'h1234);
        rd(8'he8, 16'h07ff);
        rd(8'he9, 16'h0000);
        `CHK("io_ready", 1'b1, io_ready)
        wr(8'hec, 16'hf800);
        wr(8'hed, 16'h07ff);
        `CHK("volt1", 12'h800, v1)
        tick();
        `CHK("volt1", 12'h000, v1)
        `CHK("volt2", 12'hfff, v2)
        `CHK("curr1", 12'h000, c1)
        `CHK("curr2", 12'hffe, c2)
        rd(8'hec, 16'hf800);
        wr(8'hfe, 16'hffff);
        rd(8'hfe, 16'h7fff);
        for (int i = 0; i < 2; i++) begin
            flt = 2'(i + 1);
            repeat (6) step();
            rd(8'h04, (i == 1) ? 16'h0400 : 16'h0100);
            rd(8'hfe, 16'hffff);
            `CHK("io_ready", 1'b0, io_ready)
            flt = 2'b00;
            repeat (6) step();
            rd(8'hfe, 16'h7fff);
        end
        do_reset();
        wr(8'hf0, 16'h1000);
        tick();
        repeat (4) step();
        rd(8'h04, 16'h0300);
        rd(8'hfe, 16'h8000);
        print_verdict();
    end
endmodule // aio_scan_interface_tb_top
`default_nettype wire
